//--- bench/spi_host_model.sv
`timescale 1ns/100ps
// Behavioural host: drives select, serial clock, data and pause pins.
module spi_host_model (
    input  wire logic sys_clk,
    input  wire logic soOut,
    output logic      csPinN,
    output logic      sckPin,
    output logic      siPin,
    output logic      holdPinN
);
    // Pins start idle: deselected, clock low, pause released.
    initial begin
        csPinN   = 1'b1;
        sckPin   = 1'b0;
        siPin    = 1'b0;
        holdPinN = 1'b1;
    end

    // Waits falling edges; 6 low and 7 high gives a 65 ns link period.
    task automatic half(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : half

    // Moves the clock pin alone, for the pause timing cases.
    task automatic sck_set(input logic v);
        sckPin <= v;
        half(7);
    endtask : sck_set

    // Moves the pause pin; select is never touched here.
    task automatic hold_set(input logic v);
        holdPinN <= v;
        half(7);
    endtask : hold_set

    // Selects with the clock low; pause is released first so it cannot re-enter.
    task automatic select();
        if (holdPinN !== 1'b1) begin
            holdPinN <= 1'b1;
            half(7);
        end
        csPinN <= 1'b0;
        half(7);
    endtask : select

    // Ends the frame; the released data line shows the inverse of its last value.
    task automatic deselect();
        csPinN <= 1'b1;
        siPin  <= ~siPin;
        half(7);
    endtask : deselect

    // One bit: data set with the clock low, output read just before the rise.
    task automatic bit_x(input logic d, output logic q);
        siPin <= d;
        half(6);
        q = soOut;
        sckPin <= 1'b1;
        half(7);
        sckPin <= 1'b0;
    endtask : bit_x

    // A whole byte, most significant bit first.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    endtask : xfer
endmodule : spi_host_model

//--- bench/tb_flash_hold_core.sv
`timescale 1ns/100ps
`include "flash_defs.svh"
// Self-checking bench for the pause logic, page program and erase engine.
module tb_flash_hold_core
    import flash_pkg::*;
;
    logic               sys_clk, rst, boostPin, bufWrEn, progStart, eraseStart;
    logic               csPinN, sckPin, siPin, holdPinN, soOut, soOeN;
    logic               holdActive, programBoost, cmdStart, rxValid, busy, arrayRdEn, arrayWrEn;
    logic [7:0]         cfgReg, txByte, rxByte, bufWrIdx, bufWrData, arrayRdData, arrayWrData;
    logic [8:0]         progLen;
    logic [6:0]         eraseSector;
    logic [`ADDR_W-1:0] progAddr, eraseAddr, arrayAddr;
    erase_kind_t        eraseKind;
    int                 errors, compares, cmdCount, rxCount, rdCount;
    logic [30:0]        wrLog[$];  // Every array write: address then data.

    spi_host_model host (.sys_clk(sys_clk), .soOut(soOut), .csPinN(csPinN), .sckPin(sckPin),
        .siPin(siPin), .holdPinN(holdPinN));

    flash_hold_core DUT (.sys_clk(sys_clk), .rst(rst), .csPinN(csPinN), .sckPin(sckPin),
        .siPin(siPin), .holdPinN(holdPinN), .boostPin(boostPin), .soOut(soOut), .soOeN(soOeN),
        .cfgReg(cfgReg), .holdActive(holdActive), .programBoost(programBoost), .cmdStart(cmdStart),
        .rxValid(rxValid), .rxByte(rxByte), .txByte(txByte), .bufWrEn(bufWrEn), .bufWrIdx(bufWrIdx),
        .bufWrData(bufWrData), .progStart(progStart), .progAddr(progAddr), .progLen(progLen),
        .eraseStart(eraseStart), .eraseKind(eraseKind), .eraseAddr(eraseAddr), .busy(busy),
        .eraseSector(eraseSector), .arrayRdEn(arrayRdEn), .arrayWrEn(arrayWrEn),
        .arrayAddr(arrayAddr), .arrayWrData(arrayWrData), .arrayRdData(arrayRdData));

    // 200 MHz system clock.
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Array contents seen by a read; depends on the two low address bytes.
    function automatic logic [7:0] rdPat(input logic [`ADDR_W-1:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h96;
    endfunction : rdPat

    // Array model and monitors work at the falling edge, where outputs are settled.
    always @(negedge sys_clk) begin
        arrayRdData <= rdPat(arrayAddr);
        if (cmdStart === 1'b1) cmdCount++;
        if (rxValid === 1'b1) rxCount++;
        if (arrayRdEn === 1'b1) rdCount++;
        if (arrayWrEn === 1'b1) wrLog.push_back({arrayAddr, arrayWrData});
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // One comparison, counted, reported at once on a mismatch.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bounded wait for the engine to go idle.
    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        cyc(1);
        while (busy !== 1'b0 && n < lim) begin
            cyc(1);
            n++;
        end
        chk("busy", 0, busy);
    endtask : wait_idle

    // A plain byte exchange both ways.
    task automatic t_byte(input logic [7:0] tx, input logic [7:0] mosi);
        logic [7:0] rx;
        int c0;
        c0 = cmdCount;
        txByte = tx;
        host.select();
        host.xfer(mosi, rx);
        chk("rxByte", mosi, rxByte);
        host.deselect();
        chk("cmdStart", 1, cmdCount - c0);
        chk("soOut bits", tx, rx);
        chk("soOeN", 1, soOeN);
        $display("test byte done");
    endtask : t_byte

    // Pause in mid-byte with the clock low; clock pulses during it must not count.
    task automatic t_hold_std();
        logic [7:0] rx;
        logic q;
        int r0;
        r0 = rxCount;
        txByte = 8'h5a;
        host.select();
        for (int i = 7; i >= 4; i--) host.bit_x(i > 5, rx[i]);
        host.hold_set(1'b0);
        chk("holdActive", 1, holdActive);
        chk("soOeN", 1, soOeN);
        host.bit_x(1'b1, q);
        host.bit_x(1'b0, q);
        host.hold_set(1'b1);
        chk("holdActive", 0, holdActive);
        for (int i = 3; i >= 0; i--) host.bit_x(i < 2, rx[i]);
        chk("rxByte", 8'hc3, rxByte);
        chk("rxValid count", 1, rxCount - r0);
        host.deselect();
        chk("soOut bits", 8'h5a, rx);
        $display("test hold standard done");
    endtask : t_hold_std

    // Pause edges with the clock high wait for the next clock fall.
    task automatic t_hold_defer();
        host.select();
        host.sck_set(1'b1);
        host.hold_set(1'b0);
        chk("holdActive", 0, holdActive);
        host.sck_set(1'b0);
        chk("holdActive", 1, holdActive);
        host.sck_set(1'b1);
        host.hold_set(1'b1);
        chk("holdActive", 1, holdActive);
        host.sck_set(1'b0);
        chk("holdActive", 0, holdActive);
        host.deselect();
        $display("test hold deferred done");
    endtask : t_hold_defer

    // Deselect while paused resets the interface; the next frame starts anew.
    task automatic t_hold_cs();
        logic [7:0] rx;
        int c0;
        host.select();
        host.hold_set(1'b0);
        chk("holdActive", 1, holdActive);
        host.deselect();
        chk("holdActive", 0, holdActive);
        chk("soOeN", 1, soOeN);
        c0 = cmdCount;
        txByte = 8'he7;
        host.select();
        host.xfer(8'h81, rx);
        chk("rxByte", 8'h81, rxByte);
        host.deselect();
        chk("cmdStart", 1, cmdCount - c0);
        chk("soOut bits", 8'he7, rx);
        $display("test hold deselect done");
    endtask : t_hold_cs

    // Four-lane mode ignores the pause pin and blocks the program boost.
    task automatic t_quad(input logic boost);
        cfgReg = 8'h02;
        host.select();
        host.hold_set(1'b0);
        chk("holdActive", 0, holdActive);
        boostPin = boost;
        cyc(4);
        chk("programBoost", 0, programBoost);
        host.hold_set(1'b1);
        cfgReg = 8'h00;
        cyc(2);
        chk("programBoost", boost, programBoost);
        boostPin = ~boost;
        host.deselect();
        $display("test quad done");
    endtask : t_quad

    // Page program across the page end, run while the serial side is paused.
    task automatic t_program(input logic [`ADDR_W-1:0] addr, input logic [8:0] len);
        logic [`ADDR_W-1:0] a;
        int r0;
        for (int i = 0; i < 256; i++) begin
            bufWrEn   = 1'b1;
            bufWrIdx  = 8'(i);
            bufWrData = ~8'(i);
            cyc(1);
        end
        bufWrEn = 1'b0;
        host.select();
        host.hold_set(1'b0);
        wrLog.delete();
        r0        = rdCount;
        progAddr  = addr;
        progLen   = len;
        progStart = 1'b1;
        cyc(1);
        progStart = 1'b0;
        wait_idle(800);
        chk("write count", 32'(len), wrLog.size());
        chk("read count", 32'(len), rdCount - r0);
        chk("holdActive", 1, holdActive);
        for (int k = 0; k < len; k++) begin
            a = {addr[22:8], 8'(addr[7:0] + k)};
            chk("write addr", 32'(a), 32'(wrLog[k][30:8]));
            chk("write data", rdPat(a) & ~a[7:0], wrLog[k][7:0]);
        end
        host.hold_set(1'b1);
        host.deselect();
        $display("test program done");
    endtask : t_program

    // Erase of one span: every address once, in order, to all ones.
    task automatic t_erase(input erase_kind_t kind, input logic [`ADDR_W-1:0] addr, input logic [7:0] cfg,
                           input logic [`ADDR_W-1:0] lo, input logic [`ADDR_W-1:0] hi, input logic [6:0] sec);
        int bad;
        bad = 0;
        cfgReg = cfg;
        wrLog.delete();
        eraseKind  = kind;
        eraseAddr  = addr;
        eraseStart = 1'b1;
        cyc(1);
        eraseStart = 1'b0;
        wait_idle(70000);
        chk("erase count", 32'(hi - lo) + 1, wrLog.size());
        foreach (wrLog[k]) if (wrLog[k][7:0] !== 8'hff || wrLog[k][30:8] !== lo + 23'(k)) bad++;
        chk("erase bad writes", 0, bad);
        chk("eraseSector", 32'(sec), 32'(eraseSector));
        cfgReg = 8'h00;
        $display("test erase %0d done", kind);
    endtask : t_erase

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    // Watchdog sized above all four erases plus the serial tests.
    initial begin
        cyc(98000);
        errors++;
        results();
    end

    // Main sequence.
    initial begin
        rst = 1'b1; cfgReg = 8'h00; boostPin = 1'b0; txByte = 8'h00;
        bufWrEn = 1'b0; bufWrIdx = 8'h00; bufWrData = 8'h00; progStart = 1'b0; progAddr = '0;
        progLen = 9'h000; eraseStart = 1'b0; eraseKind = ERASE_SECTOR; eraseAddr = '0;
        cyc(6);
        rst = 1'b0;
        cyc(3);
        t_byte(8'h3c, 8'ha5);
        t_hold_std();
        t_hold_defer();
        t_hold_cs();
        t_quad(1'b1);
        t_program(23'h0123fe, 9'h004);
        t_program(23'h4567c0, 9'h100);
        t_erase(ERASE_4K_SUBSECTOR, 23'h01f123, 8'h00, 23'h01f000, 23'h01ffff, 7'h01);
        t_erase(ERASE_8K_SUBSECTOR, 23'h002abc, 8'h00, 23'h002000, 23'h003fff, 7'h00);
        t_erase(ERASE_4K_SUBSECTOR, 23'h7e1800, 8'h04, 23'h7e1000, 23'h7e1fff, 7'h7e);
        t_erase(ERASE_SECTOR, 23'h7f4321, 8'h00, 23'h7f0000, 23'h7fffff, 7'h7f);
        results();
    end
endmodule : tb_flash_hold_core

//--- pkg/flash_defs.svh
`ifndef FLASH_HOLD_DEFS_SVH
`define FLASH_HOLD_DEFS_SVH

// Configuration byte field positions.
`define CFG_QUAD_BIT      1
`define CFG_PARAM_TOP_BIT 2

// Array geometry.
`define ADDR_W            23
`define PAGE_BYTES        256
`define SECTOR_MSB        22
`define SECTOR_LSB        16
`define PAIR_LSB          17
`define PARAM_PAIR_BOTTOM 6'h00
`define PARAM_PAIR_TOP    6'h3f

// Erase masks, applied to the issued address.
`define MASK_4K           23'h000fff
`define MASK_8K           23'h001fff
`define MASK_SECTOR       23'h00ffff
`define MASK_ARRAY        23'h7fffff

// Data values and serial framing.
`define ERASED_BYTE       8'hff
`define BYTE_LAST         3'h7
`define BIT_FIRST         3'h0
`define SYNC_IDLE         5'h18

`endif

//--- pkg/flash_pkg.sv
package flash_pkg;

    // Erase granularity chosen by the issued erase command.
    typedef enum logic [1:0] {
        ERASE_4K_SUBSECTOR = 2'h0,
        ERASE_8K_SUBSECTOR = 2'h1,
        ERASE_SECTOR       = 2'h2,
        ERASE_WHOLE_ARRAY  = 2'h3
    } erase_kind_t;

    // Array engine states, one-hot.
    typedef enum logic [4:0] {
        ENG_IDLE   = 5'b00001,
        ENG_READ   = 5'b00010,
        ENG_MERGE  = 5'b00100,
        ENG_COMMIT = 5'b01000,
        ENG_ERASE  = 5'b10000
    } eng_state_t;

endpackage : flash_pkg

//--- rtl/flash_hold_core.sv
// Summary of operation
// - Pause never stops register, program, erase work.
// - Pause starts on pause fall, clock low.
// - Pause fall with clock high waits clock fall.
// - Pause ends on pause rise, clock low.
// - Pause rise with clock high waits clock fall.
// - Paused: output floats, input and clock ignored.
// - Select high while paused resets the interface.
// - Four-lane mode disables the pause function.
// - Four-lane mode disables the program boost.
// - Program data waits in a page buffer.
// - Programming only clears bits to zero.
// - Erase sets bits by sub-sector, sector, array.
// - Array decodes as 128 sectors of 64 kB.
// - Bottom placement splits two lowest sectors into 4 kB.
// - Configuration bit 2 selects top or bottom placement.
// - Configuration bit 1 selects four-lane mode.
`timescale 1ns/100ps
`include "flash_defs.svh"
module flash_hold_core
    import flash_pkg::*;
#(
    parameter int PAGE_BYTES = `PAGE_BYTES,
    parameter int IDX_W      = $clog2(PAGE_BYTES)
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               csPinN,      // Chip select pin, low selects.
    input  wire logic               sckPin,      // Serial clock pin.
    input  wire logic               siPin,       // Serial data in pin.
    input  wire logic               holdPinN,    // Pause pin, low pauses.
    input  wire logic               boostPin,    // Boost level seen on write_protect_boost_pin.
    output logic                    soOut,       // Serial data out.
    output logic                    soOeN,       // Low while the output is driven.
    input  wire logic [7:0]         cfgReg,      // Configuration byte.
    output logic                    holdActive,  // Pause state.
    output logic                    programBoost,// Boosted programming allowed.
    output logic                    cmdStart,    // New command frame begins.
    output logic                    rxValid,     // A byte was received.
    output logic [7:0]              rxByte,
    input  wire logic [7:0]         txByte,      // Next byte to shift out.
    input  wire logic               bufWrEn,     // Page buffer load.
    input  wire logic [IDX_W-1:0]   bufWrIdx,
    input  wire logic [7:0]         bufWrData,
    input  wire logic               progStart,
    input  wire logic [`ADDR_W-1:0] progAddr,
    input  wire logic [IDX_W:0]     progLen,
    input  wire logic               eraseStart,
    input  wire erase_kind_t        eraseKind,
    input  wire logic [`ADDR_W-1:0] eraseAddr,
    output logic                    busy,
    output logic [6:0]              eraseSector,
    output logic                    arrayRdEn,
    output logic                    arrayWrEn,
    output logic [`ADDR_W-1:0]      arrayAddr,
    output logic [7:0]              arrayWrData,
    input  wire logic [7:0]         arrayRdData  // Valid the cycle after arrayRdEn.
);
    // Synchronised pin levels and their previous samples.
    logic [4:0] pinSync;
    logic       csPrevN;
    logic       sckPrev;
    logic       holdPrevN;

    // Pause state and pending transitions.
    logic       holdState;
    logic       pendEnter;
    logic       pendExit;

    // Serial front end.
    logic [2:0] bitCnt;
    logic [6:0] shiftIn;
    logic [6:0] txShift;

    // Array engine.
    eng_state_t             engState;
    logic [IDX_W:0]         remain;       // Bytes still to program.
    logic [`ADDR_W-1:0]     eraseEnd;     // Last address of the erase span.
    logic [7:0]             pageBuf [PAGE_BYTES]; // Staged program data.
    wire  [`ADDR_W-1:0]     spanLo;
    wire  [`ADDR_W-1:0]     spanHi;
    wire  [6:0]             spanSector;

    // Named decodes of the synchronised pins.
    wire csN       = pinSync[4];
    wire holdN     = pinSync[3];
    wire sck       = pinSync[2];
    wire si        = pinSync[1];
    wire boost     = pinSync[0];
    wire csActive  = ~csN;
    wire csFall    = csActive & csPrevN;
    wire sckRise   = sck & ~sckPrev;
    wire sckFall   = ~sck & sckPrev;
    wire holdFall  = ~holdN & holdPrevN;
    wire holdRise  = holdN & ~holdPrevN;
    wire quadMode  = cfgReg[`CFG_QUAD_BIT];
    wire holdAllow = ~quadMode;
    wire frontRun  = csActive & ~holdState;
    wire engIdle   = (engState == ENG_IDLE);

    // All pins pass two flops before anything looks at them.
    pin_sync #(
        .WIDTH     (5),
        .RESET_VAL (`SYNC_IDLE)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn ({csPinN, holdPinN, sckPin, siPin, boostPin}),
        .syncOut (pinSync)
    );

    // Address decode for erase spans and sector numbers.
    sector_map u_sector_map (
        .addr      (eraseAddr),
        .paramTop  (cfgReg[`CFG_PARAM_TOP_BIT]),
        .kind      (eraseKind),
        .sectorIdx (spanSector),
        .rangeLo   (spanLo),
        .rangeHi   (spanHi)
    );

    // The boost path shares a pin with a data lane in four-lane mode.
    assign programBoost = boost & ~quadMode;
    assign holdActive   = holdState;
    // The output floats whenever the frame is idle or paused.
    assign soOeN        = ~frontRun;
    assign busy         = ~engIdle;
    assign arrayRdEn    = (engState == ENG_READ);
    assign arrayWrEn    = (engState == ENG_COMMIT) | (engState == ENG_ERASE);

    // Previous samples give edge detection on the synchronised levels.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            csPrevN   <= 1'b1;
            sckPrev   <= 1'b0;
            holdPrevN <= 1'b1;
        end else begin
            csPrevN   <= csN;
            sckPrev   <= sck;
            holdPrevN <= holdN;
        end
    end

    // Pause tracking. Deselect or four-lane mode clears it outright, so a
    // host may select again with the pause pin still low; only a new pause fall re-enters.
    always_ff @(posedge sys_clk) begin
        if (rst || !csActive || !holdAllow) begin
            holdState <= 1'b0;
            pendEnter <= 1'b0;
            pendExit  <= 1'b0;
        end else if (!holdState) begin
            if (holdFall && !sck) begin
                holdState <= 1'b1;
            end else if (holdFall) begin
                pendEnter <= 1'b1;
            end else if (pendEnter && holdRise) begin
                pendEnter <= 1'b0;
            end else if (pendEnter && sckFall) begin
                holdState <= 1'b1;
                pendEnter <= 1'b0;
            end
        end else begin
            if (holdRise && !sck) begin
                holdState <= 1'b0;
            end else if (holdRise) begin
                pendExit <= 1'b1;
            end else if (pendExit && holdFall) begin
                pendExit <= 1'b0;
            end else if (pendExit && sckFall) begin
                holdState <= 1'b0;
                pendExit  <= 1'b0;
            end
        end
    end

    // Receive side: sample on rising clock edges only while the frame runs.
    always_ff @(posedge sys_clk) begin
        if (rst || !csActive) begin
            bitCnt  <= `BIT_FIRST;
            shiftIn <= 7'h00;
            rxValid <= 1'b0;
            rxByte  <= 8'h00;
        end else begin
            rxValid <= 1'b0;
            // Paused clock and data edges are dropped, not queued.
            if (sckRise && frontRun) begin
                shiftIn <= {shiftIn[5:0], si};
                bitCnt  <= bitCnt + 3'h1;
                if (bitCnt == `BYTE_LAST) begin
                    rxByte  <= {shiftIn, si};
                    rxValid <= 1'b1;
                end
            end
        end
    end

    // Transmit side: first bit shows at select, the rest on falling edges.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            soOut   <= 1'b0;
            txShift <= 7'h00;
        end else if (csFall || (sckFall && frontRun && bitCnt == `BIT_FIRST)) begin
            soOut   <= txByte[7];
            txShift <= txByte[6:0];
        end else if (sckFall && frontRun) begin
            soOut   <= txShift[6];
            txShift <= {txShift[5:0], 1'b0};
        end
    end

    // A select edge always marks a fresh command after any interface reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmdStart <= 1'b0;
        end else begin
            cmdStart <= csFall;
        end
    end

    // Page buffer: no reset, it is always loaded before it is committed.
    always_ff @(posedge sys_clk) begin
        if (bufWrEn) begin
            pageBuf[bufWrIdx] <= bufWrData;
        end
    end

    // Array engine. It never looks at the serial front end, so a pause
    // cannot stall an operation already started.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            engState    <= ENG_IDLE;
            remain      <= '0;
            eraseEnd    <= '0;
            eraseSector <= 7'h00;
            arrayAddr   <= '0;
            arrayWrData <= 8'h00;
        end else begin
            case (engState)
                ENG_IDLE: begin
                    if (progStart && progLen != '0) begin
                        arrayAddr <= progAddr;
                        remain    <= progLen;
                        engState  <= ENG_READ;
                    end else if (eraseStart) begin
                        arrayAddr   <= spanLo;
                        eraseEnd    <= spanHi;
                        eraseSector <= spanSector;
                        arrayWrData <= `ERASED_BYTE;
                        engState    <= ENG_ERASE;
                    end
                end
                ENG_READ: begin
                    engState <= ENG_MERGE;
                end
                ENG_MERGE: begin
                    // An AND with the old contents can only clear bits.
                    arrayWrData <= arrayRdData & pageBuf[arrayAddr[IDX_W-1:0]];
                    engState    <= ENG_COMMIT;
                end
                ENG_COMMIT: begin
                    // Addresses wrap inside the page, as the buffer does.
                    arrayAddr <= {arrayAddr[`ADDR_W-1:IDX_W], arrayAddr[IDX_W-1:0] + 1'b1};
                    remain    <= remain - 1'b1;
                    engState  <= (remain == 1) ? ENG_IDLE : ENG_READ;
                end
                ENG_ERASE: begin
                    // One byte per cycle; a whole-array erase is long by nature.
                    if (arrayAddr == eraseEnd) begin
                        engState <= ENG_IDLE;
                    end else begin
                        arrayAddr <= arrayAddr + 1'b1;
                    end
                end
                default: begin
                    engState <= ENG_IDLE;
                end
            endcase
        end
    end

    property p_enter_low;
        @(posedge sys_clk) disable iff (rst)
        (csActive && holdAllow && !holdState && holdFall && !sck) |=> holdState;
    endproperty
    a_enter_low: assert property (p_enter_low) else $error("pause not entered");

    property p_enter_defer;
        @(posedge sys_clk) disable iff (rst)
        (!holdState && holdFall && sck) |=> !holdState;
    endproperty
    a_enter_defer: assert property (p_enter_defer) else $error("pause entered early");

    property p_exit_low;
        @(posedge sys_clk) disable iff (rst)
        (holdState && holdRise && !sck) |=> !holdState;
    endproperty
    a_exit_low: assert property (p_exit_low) else $error("pause not left");

    property p_exit_defer;
        @(posedge sys_clk) disable iff (rst)
        (holdState && holdRise && sck && csActive && holdAllow) ##1 (csActive && holdAllow && !sckFall)
            |=> holdState;
    endproperty
    a_exit_defer: assert property (p_exit_defer) else $error("pause left early");

    property p_frozen;
        @(posedge sys_clk) disable iff (rst)
        (holdState && csActive) |-> soOeN ##1 (!csActive || (bitCnt == $past(bitCnt) && !rxValid));
    endproperty
    a_frozen: assert property (p_frozen) else $error("front end moved while paused");

    property p_deselect;
        @(posedge sys_clk) disable iff (rst)
        !csActive |=> (!holdState && bitCnt == `BIT_FIRST);
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect did not reset");

    property p_quad;
        @(posedge sys_clk) disable iff (rst)
        quadMode |=> (!holdState && !pendEnter);
    endproperty
    a_quad: assert property (p_quad) else $error("pause in four-lane mode");

    property p_clear_only;
        @(posedge sys_clk) disable iff (rst)
        (engState == ENG_COMMIT) |-> ((arrayWrData & ~$past(arrayRdData)) == 8'h00);
    endproperty
    a_clear_only: assert property (p_clear_only) else $error("program set a bit");

    property p_run_on;
        @(posedge sys_clk) disable iff (rst)
        (engState == ENG_READ) |=> (engState == ENG_MERGE) ##1 (engState == ENG_COMMIT);
    endproperty
    a_run_on: assert property (p_run_on) else $error("program stalled");
endmodule : flash_hold_core

//--- rtl/pin_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for a group of pins from outside the clock domain.
module pin_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta; // First stage, read only by the second stage.

    // Both stages take the idle level of the pins at reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta    <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            meta    <= asyncIn;
            syncOut <= meta;
        end
    end
endmodule : pin_sync

//--- rtl/sector_map.sv
`timescale 1ns/100ps
`include "flash_defs.svh"
// Decodes an array address into its sector and the span an erase covers.
module sector_map
    import flash_pkg::*;
(
    input  wire logic [`ADDR_W-1:0] addr,
    input  wire logic               paramTop,
    input  wire erase_kind_t        kind,
    output logic [6:0]              sectorIdx,
    output logic [`ADDR_W-1:0]      rangeLo,
    output logic [`ADDR_W-1:0]      rangeHi
);
    wire [5:0]         pairIdx;  // Which pair of sectors holds the address.
    wire [5:0]         paramPair; // Pair split into 4 kB sub-sectors.
    wire               inParam;  // Address lies in the split pair.
    wire [`ADDR_W-1:0] mask;     // Bits that the erase span covers.

    // Every sector is 64 kB, so the top address bits name it directly.
    assign sectorIdx = addr[`SECTOR_MSB:`SECTOR_LSB];
    assign pairIdx   = addr[`SECTOR_MSB:`PAIR_LSB];

    // The split pair sits at the bottom unless the top placement is chosen.
    assign paramPair = paramTop ? `PARAM_PAIR_TOP : `PARAM_PAIR_BOTTOM;
    assign inParam   = (pairIdx == paramPair);

    // Sub-sector erases outside the split pair fall back to the whole sector,
    // which keeps the span aligned and never leaks into a neighbour.
    assign mask = (kind == ERASE_WHOLE_ARRAY)               ? `MASK_ARRAY :
                  (kind == ERASE_4K_SUBSECTOR && inParam)   ? `MASK_4K    :
                  (kind == ERASE_8K_SUBSECTOR && inParam)   ? `MASK_8K    :
                  `MASK_SECTOR;

    assign rangeLo = addr & ~mask;
    assign rangeHi = addr | mask;
endmodule : sector_map
